/* File: core/cvd_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the sequencer and the bench only
`ifndef CVD_DEFINES_SVH
`define CVD_DEFINES_SVH
`define CVD_OFF_CLKREF   12'h000
`define CVD_OFF_TRIG     12'h004
`define CVD_OFF_PRECTL   12'h008
`define CVD_OFF_STAT     12'h00C
`define CVD_OFF_PRE      12'h010
`define CVD_OFF_ACQ      12'h014
`define CVD_OFF_GRD      12'h018
`define CVD_OFF_CTRL     12'h01C
`define CVD_RST_BYTE     8'h00
`define CVD_B_JUSTIFY    7
`define CVD_B_EXT_POL    7
`define CVD_B_INT_POL    6
`define CVD_B_LOWZ       5
`define CVD_B_PASS       4
`define CVD_B_OVR        3
`define CVD_B_INV        1
`define CVD_B_DBL        0
`define CVD_B_GRD_B      7
`define CVD_B_GRD_A      6
`define CVD_B_GRD_POL    5
`define CVD_B_GO         1
`define CVD_B_ON         0
`define CVD_STG_IDLE     2'b00
`define CVD_STG_PRE      2'b01
`define CVD_STG_ACQ      2'b10
`define CVD_STG_CONV     2'b11
`define CVD_CONV_TADS    11
`define CVD_INSTR_DIV    4
`define CVD_RC_DIV       16
`endif

/* File: core/cvd_pkg.sv */
// types shared by the sequencer
// assumes cvd_defines.svh is available on the include path
package cvd_pkg;
    typedef enum logic [1:0] {
        CVD_IDLE,
        CVD_PRE,
        CVD_ACQ,
        CVD_CONV
    } cvd_stage_t;
    typedef logic [7:0] cvd_byte_t;
endpackage

/* File: core/cvd_seq.sv */
// capacitive divider conversion sequencer with apb register slave
// assumes one 100 MHz clock; converter data arrives as a 10 bit word
`timescale 1ns/10ps
`include "cvd_defines.svh"
module cvd_seq (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // trigger sources, the flag set strobes of each peer
    input  wire logic        trig_ccp_one,
    input  wire logic        trig_ccp_two,
    input  wire logic        trig_timer_zero,
    input  wire logic        trig_timer_one,
    input  wire logic        trig_timer_two,
    // converter data
    input  wire logic [9:0]  conv_result,
    // analog controls
    output logic [2:0]       conv_clock_sel,
    output logic [1:0]       pos_ref_sel,
    output logic             conv_clock_en,
    output logic             ext_precharge_vdd,
    output logic             ext_precharge_active,
    output logic             hold_precharge_vdd,
    output logic             hold_precharge_active,
    output logic             aout_lowz_close,
    output logic             aout_pass_close,
    output logic             aout_override_en,
    output logic             aout_override_val,
    // guard pins, oe low while driving
    output logic             guard_pin_a_o,
    output logic             guard_pin_a_oe_n,
    output logic             guard_pin_b_o,
    output logic             guard_pin_b_oe_n,
    // results
    output logic [7:0]       result0_high_byte,
    output logic [7:0]       result0_low_byte,
    output logic [7:0]       result1_high_byte,
    output logic [7:0]       result1_low_byte,
    output logic             conv_done
);
    import cvd_pkg::*;

    cvd_byte_t  clkref_q, trig_q, prectl_q, pre_q, acq_q, grd_q;
    logic       go_q, on_q, second_q;
    cvd_stage_t stage_q;
    logic [6:0] tmr_q;
    logic [3:0] div_q;
    logic       tick;
    logic       rc_sel;
    logic       trig_sel, trig_d1_q, trig_rise;
    logic       wr, rd, go_set;
    logic       inv;
    logic       grd_lvl;
    logic [9:0] res_latched;

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // rc clock choice
    assign rc_sel = (clkref_q[5:4] == 2'b11);
    assign conv_clock_sel = clkref_q[6:4];
    assign pos_ref_sel = clkref_q[1:0];

    // stage timing tick: instruction cycle or slow rc enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 4'h0;
        end else if (stage_q == CVD_IDLE) begin
            div_q <= 4'h0;
        end else if (tick) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end
    assign tick = rc_sel ? (div_q == 4'(`CVD_RC_DIV - 1))
                         : (div_q == 4'(`CVD_INSTR_DIV - 1));

    // selected trigger, the same strobe that sets each peer's flag
    always_comb begin
        unique case (trig_q[6:4])
            3'b001:  trig_sel = trig_ccp_one;
            3'b010:  trig_sel = trig_ccp_two;
            3'b011:  trig_sel = trig_timer_zero;
            3'b100:  trig_sel = trig_timer_one;
            3'b101:  trig_sel = trig_timer_two;
            default: trig_sel = 1'b0;
        endcase
    end

    // rising edge detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_d1_q <= 1'b0;
        end else begin
            trig_d1_q <= trig_sel;
        end
    end
    assign trig_rise = trig_sel & ~trig_d1_q;

    assign go_set = (wr && paddr == `CVD_OFF_CTRL && pwdata[`CVD_B_GO]) || trig_rise;

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clkref_q <= `CVD_RST_BYTE;
            trig_q   <= `CVD_RST_BYTE;
            prectl_q <= `CVD_RST_BYTE;
            pre_q    <= `CVD_RST_BYTE;
            acq_q    <= `CVD_RST_BYTE;
            grd_q    <= `CVD_RST_BYTE;
            on_q     <= 1'b0;
        end else if (wr) begin
            unique case (paddr)
                `CVD_OFF_CLKREF: clkref_q <= pwdata[7:0] & 8'hF3;
                `CVD_OFF_TRIG:   trig_q   <= pwdata[7:0] & 8'h70;
                `CVD_OFF_PRECTL: prectl_q <= pwdata[7:0] & 8'hFB;
                `CVD_OFF_PRE:    pre_q    <= pwdata[7:0] & 8'h7F;
                `CVD_OFF_ACQ:    acq_q    <= pwdata[7:0] & 8'h7F;
                `CVD_OFF_GRD:    grd_q    <= pwdata[7:0] & 8'hE0;
                `CVD_OFF_CTRL:   on_q     <= pwdata[`CVD_B_ON];
                default: ;
            endcase
        end
    end

    // sequence state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q  <= CVD_IDLE;
            tmr_q    <= 7'h00;
            go_q     <= 1'b0;
            second_q <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            unique case (stage_q)
                CVD_IDLE: begin
                    if (go_set && on_q) begin
                        go_q <= 1'b1;
                        second_q <= 1'b0;
                        if (pre_q[6:0] != 7'h00) begin
                            stage_q <= CVD_PRE;
                            tmr_q <= pre_q[6:0];
                        end else if (acq_q[6:0] != 7'h00) begin
                            stage_q <= CVD_ACQ;
                            tmr_q <= acq_q[6:0];
                        end else begin
                            stage_q <= CVD_CONV;
                            tmr_q <= 7'(`CVD_CONV_TADS);
                        end
                    end
                end
                CVD_PRE: if (tick) begin
                    if (tmr_q == 7'h01) begin
                        if (acq_q[6:0] != 7'h00) begin
                            stage_q <= CVD_ACQ;
                            tmr_q <= acq_q[6:0];
                        end else begin
                            stage_q <= CVD_CONV;
                            tmr_q <= 7'(`CVD_CONV_TADS);
                        end
                    end else begin
                        tmr_q <= tmr_q - 7'h01;
                    end
                end
                CVD_ACQ: if (tick) begin
                    if (tmr_q == 7'h01) begin
                        stage_q <= CVD_CONV;
                        tmr_q <= 7'(`CVD_CONV_TADS);
                    end else begin
                        tmr_q <= tmr_q - 7'h01;
                    end
                end
                CVD_CONV: if (tick) begin
                    if (tmr_q == 7'h01) begin
                        if (prectl_q[`CVD_B_DBL] && !second_q) begin
                            second_q <= 1'b1;
                            if (pre_q[6:0] != 7'h00) begin
                                stage_q <= CVD_PRE;
                                tmr_q <= pre_q[6:0];
                            end else if (acq_q[6:0] != 7'h00) begin
                                stage_q <= CVD_ACQ;
                                tmr_q <= acq_q[6:0];
                            end else begin
                                tmr_q <= 7'(`CVD_CONV_TADS);
                            end
                        end else begin
                            stage_q <= CVD_IDLE;
                            go_q <= 1'b0;
                            second_q <= 1'b0;
                            conv_done <= 1'b1;
                        end
                    end else begin
                        tmr_q <= tmr_q - 7'h01;
                    end
                end
            endcase
            if (!on_q) begin
                stage_q <= CVD_IDLE;
                go_q <= 1'b0;
                second_q <= 1'b0;
            end
        end
    end

    // result capture in selected justification
    assign res_latched = conv_result;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result0_high_byte <= 8'h00;
            result0_low_byte  <= 8'h00;
            result1_high_byte <= 8'h00;
            result1_low_byte  <= 8'h00;
        end else if (stage_q == CVD_CONV && tick && tmr_q == 7'h01) begin
            if (second_q) begin
                if (clkref_q[`CVD_B_JUSTIFY]) begin
                    result1_high_byte <= {6'h00, res_latched[9:8]};
                    result1_low_byte  <= res_latched[7:0];
                end else begin
                    result1_high_byte <= res_latched[9:2];
                    result1_low_byte  <= {res_latched[1:0], 6'h00};
                end
            end else begin
                if (clkref_q[`CVD_B_JUSTIFY]) begin
                    result0_high_byte <= {6'h00, res_latched[9:8]};
                    result0_low_byte  <= res_latched[7:0];
                end else begin
                    result0_high_byte <= res_latched[9:2];
                    result0_low_byte  <= {res_latched[1:0], 6'h00};
                end
            end
        end
    end

    // effective polarities, stored bits left untouched
    assign inv = prectl_q[`CVD_B_DBL] & prectl_q[`CVD_B_INV] & second_q;
    assign ext_precharge_vdd = prectl_q[`CVD_B_EXT_POL] ^ inv;
    assign hold_precharge_vdd = prectl_q[`CVD_B_INT_POL] ^ inv;
    assign ext_precharge_active = (stage_q == CVD_PRE);
    assign hold_precharge_active = (stage_q == CVD_PRE);
    assign aout_lowz_close = prectl_q[`CVD_B_LOWZ];
    assign aout_pass_close = prectl_q[`CVD_B_PASS];
    assign aout_override_en = prectl_q[`CVD_B_OVR] & (stage_q == CVD_PRE);
    assign aout_override_val = hold_precharge_vdd;
    assign conv_clock_en = (stage_q == CVD_CONV);

    // guard level: start polarity in precharge, a flips at acquisition
    // decoded from the live stage so a flips on the very edge acquisition begins
    always_comb begin
        if (stage_q == CVD_ACQ) begin
            grd_lvl = grd_q[`CVD_B_GRD_POL] ^ inv ^ 1'b1;
        end else begin
            grd_lvl = grd_q[`CVD_B_GRD_POL] ^ inv;
        end
    end
    assign guard_pin_a_o = grd_lvl;
    assign guard_pin_b_o = grd_q[`CVD_B_GRD_POL] ^ inv;
    assign guard_pin_a_oe_n = ~(on_q & grd_q[`CVD_B_GRD_A]);
    assign guard_pin_b_oe_n = ~(on_q & grd_q[`CVD_B_GRD_B]);

    // read mux
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            unique case (paddr)
                `CVD_OFF_CLKREF: prdata <= {24'h00_0000, clkref_q};
                `CVD_OFF_TRIG:   prdata <= {24'h00_0000, trig_q};
                `CVD_OFF_PRECTL: prdata <= {24'h00_0000, prectl_q};
                `CVD_OFF_STAT:   prdata <= {29'h0000_0000, second_q, stage_q};
                `CVD_OFF_PRE:    prdata <= {24'h00_0000, pre_q};
                `CVD_OFF_ACQ:    prdata <= {24'h00_0000, acq_q};
                `CVD_OFF_GRD:    prdata <= {24'h00_0000, grd_q};
                `CVD_OFF_CTRL:   prdata <= {30'h0000_0000, go_q, on_q};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end

    // checks
    a_stat_idle_go: assert property (@(posedge pclk) disable iff (!presetn)
        (stage_q == CVD_IDLE) |-> (!go_q && !second_q)) else $error("idle with busy");
    a_pre_skip: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(go_q) && pre_q[6:0] == 7'h00) |-> stage_q != CVD_PRE) else $error("pre not skipped");
    a_inv_single: assert property (@(posedge pclk) disable iff (!presetn)
        !prectl_q[`CVD_B_DBL] |-> ext_precharge_vdd == prectl_q[`CVD_B_EXT_POL]) else $error("inv in single");
    a_ovr_pre_only: assert property (@(posedge pclk) disable iff (!presetn)
        aout_override_en |-> stage_q == CVD_PRE) else $error("override outside pre");
    a_grd_off: assert property (@(posedge pclk) disable iff (!presetn)
        !on_q |-> guard_pin_a_oe_n && guard_pin_b_oe_n) else $error("guard while off");
    a_seq_order: assert property (@(posedge pclk) disable iff (!presetn)
        (stage_q == CVD_ACQ) |=> stage_q inside {CVD_ACQ, CVD_CONV, CVD_IDLE}) else $error("bad order");
    a_trig_rise: assert property (@(posedge pclk) disable iff (!presetn)
        (trig_rise) |-> $past(!trig_sel)) else $error("level trigger");
    a_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done |-> !go_q && stage_q == CVD_IDLE) else $error("go not cleared");
endmodule

/* File: dv/cvd_sh_model.sv */
// behavioural sample-and-hold feeding converter data to the sequencer
// assumes the sequencer raises conv_clock_en for the whole conversion stage
`timescale 1ns/10ps
module cvd_sh_model #(
    parameter logic [9:0] BASE = 10'h2a5,
    parameter logic [9:0] STEP = 10'h0c3
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // converter side
    input  wire logic       conv_clock_en,
    output logic      [9:0] conv_result
);
    logic conv_q;
    // next sample appears only once a conversion has finished
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_result <= BASE;
            conv_q      <= 1'b0;
        end else begin
            conv_q <= conv_clock_en;
            if (conv_q && !conv_clock_en) begin
                conv_result <= conv_result + STEP;
            end
        end
    end
endmodule

/* File: dv/cvd_adc_sequencer_control_bench.sv */
// self-checking bench for the cvd sequencer over apb
// assumes zero-wait apb slave and byte registers in the low bits
`timescale 1ns/10ps
`include "cvd_defines.svh"
module cvd_adc_sequencer_control_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, conv_clock_en, conv_done, conv_q = 1'b0;
    logic        ext_vdd, ext_act, hold_vdd, hold_act, lowz, pass, ovr_en, ovr_val;
    logic        ga, ga_oe_n, gb, gb_oe_n;
    logic [4:0]  trig_v = 5'h00;
    logic [9:0]  conv_result, v_prev = 10'h000, v_last = 10'h000;
    logic [2:0]  clk_sel;
    logic [1:0]  ref_sel;
    logic [7:0]  r0h, r0l, r1h, r1l, q;
    logic [15:0] pre_n = 16'h0000, conv_n = 16'h0000, done_n = 16'h0000, cyc = 16'h0000;
    int          failures = 0, total_checks = 0;
    // clock at 100 MHz
    always #5 pclk = ~pclk;
    cvd_seq i_cvd_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_ccp_one(trig_v[0]), .trig_ccp_two(trig_v[1]),
        .trig_timer_zero(trig_v[2]), .trig_timer_one(trig_v[3]), .trig_timer_two(trig_v[4]),
        .conv_result(conv_result), .conv_clock_sel(clk_sel), .pos_ref_sel(ref_sel),
        .conv_clock_en(conv_clock_en), .ext_precharge_vdd(ext_vdd),
        .ext_precharge_active(ext_act), .hold_precharge_vdd(hold_vdd),
        .hold_precharge_active(hold_act), .aout_lowz_close(lowz), .aout_pass_close(pass),
        .aout_override_en(ovr_en), .aout_override_val(ovr_val), .guard_pin_a_o(ga),
        .guard_pin_a_oe_n(ga_oe_n), .guard_pin_b_o(gb), .guard_pin_b_oe_n(gb_oe_n),
        .result0_high_byte(r0h), .result0_low_byte(r0l), .result1_high_byte(r1h),
        .result1_low_byte(r1l), .conv_done(conv_done));
    cvd_sh_model i_cvd_sh_model (.pclk(pclk), .presetn(presetn),
        .conv_clock_en(conv_clock_en), .conv_result(conv_result));
    // stage cycle counters, samples taken per conversion, hang guard
    always @(posedge pclk) begin
        cyc    <= cyc + 16'h0001;
        pre_n  <= pre_n + ext_act;
        conv_n <= conv_n + conv_clock_en;
        done_n <= done_n + conv_done;
        conv_q <= conv_clock_en;
        if (conv_clock_en && !conv_q) begin
            v_prev <= v_last;
            v_last <= conv_result;
        end
        if (cyc == 16'd20000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, setup then access held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
        @(negedge pclk); // let the written register settle before outputs are looked at
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check_val({8'h00, q}, {8'h00, exp});
    endtask
    // wait at falling edges for precharge (0) or conversion (1) to reach a level
    task automatic till(input int which, input logic lvl);
        do @(negedge pclk); while ((which == 0 ? ext_act : conv_clock_en) !== lvl);
    endtask
    task automatic wait_done(output int n);
        n = 0;
        do begin @(posedge pclk); n++; end while (conv_done !== 1'b1);
        @(negedge pclk);
    endtask
    function automatic logic [15:0] fmt(input logic [9:0] v, input logic rj);
        return rj ? {6'b00_0000, v} : {v, 6'b00_0000};
    endfunction
    // reset values, writable masks, unmapped place, selects to ports
    task automatic t_regs();
        for (int a = 0; a < 32; a += 4) rd(a[11:0], 8'h00);
        wr(12'h020, 8'hff);
        rd(12'h020, 8'h00);
        wr(`CVD_OFF_CLKREF, 8'hff); rd(`CVD_OFF_CLKREF, 8'hf3);
        wr(`CVD_OFF_TRIG, 8'hff);   rd(`CVD_OFF_TRIG, 8'h70);
        wr(`CVD_OFF_PRECTL, 8'hff); rd(`CVD_OFF_PRECTL, 8'hfb);
        wr(`CVD_OFF_PRE, 8'hff);    rd(`CVD_OFF_PRE, 8'h7f);
        wr(`CVD_OFF_ACQ, 8'hff);    rd(`CVD_OFF_ACQ, 8'h7f);
        wr(`CVD_OFF_GRD, 8'hff);    rd(`CVD_OFF_GRD, 8'he0);
        wr(`CVD_OFF_STAT, 8'hff);   rd(`CVD_OFF_STAT, 8'h00);
        check_val({14'h0000, ga_oe_n, gb_oe_n}, 16'h0003);
        check_val({14'h0000, pready, pslverr}, 16'h0002);
        for (int c = 0; c < 8; c++) begin
            wr(`CVD_OFF_CLKREF, {1'b0, c[2:0], 2'b00, c[1:0]});
            check_val({13'h0000, clk_sel}, c[15:0]);
            check_val({14'h0000, ref_sel}, {14'h0000, c[1:0]});
        end
        for (int k = 0; k < 4; k++) begin
            wr(`CVD_OFF_PRECTL, {2'b00, k[1:0], 4'h0});
            check_val({14'h0000, lowz, pass}, k[15:0]);
        end
        $display("test registers done");
    endtask
    // every trigger code against every source, level held long
    task automatic t_trig();
        logic [15:0] d0;
        wr(`CVD_OFF_PRECTL, 8'h00); wr(`CVD_OFF_PRE, 8'h01); wr(`CVD_OFF_ACQ, 8'h00);
        wr(`CVD_OFF_CLKREF, 8'h10); // instruction clock so each cycle ends in the window
        wr(`CVD_OFF_CTRL, 8'h01);
        for (int c = 0; c < 8; c++) begin
            for (int s = 0; s < 5; s++) begin
                wr(`CVD_OFF_TRIG, {1'b0, c[2:0], 4'h0});
                @(negedge pclk);
                d0 = done_n;
                @(posedge pclk);
                trig_v <= 5'h01 << s;
                repeat (120) @(posedge pclk);
                trig_v <= 5'h00;
                repeat (5) @(negedge pclk);
                check_val(done_n - d0, {15'h0000, c == s + 1});
            end
        end
        wr(`CVD_OFF_TRIG, 8'h00);
        $display("test triggers done");
    endtask
    // single conversions: stage lengths, skips, rc timing, justify, go clear
    task automatic t_single();
        logic [15:0] p0, c0;
        int          n, tot[4];
        logic [2:0]  ck;
        logic [7:0]  pr, aq;
        logic [15:0] ep;
        for (int i = 0; i < 4; i++) begin
            ck = (i == 3) ? 3'b011 : 3'b001;
            pr = (i == 2) ? 8'h00 : (i == 3 ? 8'h02 : 8'h05);
            aq = (i == 1) ? 8'h00 : (i == 3 ? 8'h01 : 8'h03);
            ep = (i == 3) ? 16'd32 : {6'h00, pr, 2'b00};
            wr(`CVD_OFF_CLKREF, {i[0] ? 1'b0 : 1'b1, ck, 4'h0});
            wr(`CVD_OFF_PRE, pr); wr(`CVD_OFF_ACQ, aq); wr(`CVD_OFF_PRECTL, 8'h00);
            @(negedge pclk);
            p0 = pre_n; c0 = conv_n;
            wr(`CVD_OFF_CTRL, 8'h03);
            wait_done(n);
            tot[i] = n;
            check_val(pre_n - p0, ep);
            if (i < 3) check_val(conv_n - c0, 16'd44);
            check_val({r0h, r0l}, fmt(v_last, !i[0]));
            rd(`CVD_OFF_CTRL, 8'h01);
        end
        check_val(16'(tot[0] - tot[1]), 16'd12);
        $display("test single done");
    endtask
    // double sample with inversion, guards, stage and sequence status
    task automatic t_double();
        logic [15:0] d0;
        int          n;
        wr(`CVD_OFF_CLKREF, 8'h10); wr(`CVD_OFF_PRE, 8'h04); wr(`CVD_OFF_ACQ, 8'h04);
        wr(`CVD_OFF_PRECTL, 8'h8b); wr(`CVD_OFF_GRD, 8'he0);
        @(negedge pclk);
        d0 = done_n;
        wr(`CVD_OFF_CTRL, 8'h03);
        for (int p = 0; p < 2; p++) begin
            till(0, 1'b1);
            check_val({15'h0000, ext_vdd}, {15'h0000, !p[0]});
            check_val({15'h0000, hold_vdd}, p[15:0]);
            check_val({14'h0000, ovr_en, ovr_val}, {14'h0000, 1'b1, p[0]});
            check_val({14'h0000, ext_act, hold_act}, 16'h0003);
            check_val({14'h0000, ga, gb}, {14'h0000, !p[0], !p[0]});
            check_val({14'h0000, ga_oe_n, gb_oe_n}, 16'h0000);
            rd(`CVD_OFF_STAT, {5'h00, p[0], 2'b01});
            till(0, 1'b0);
            check_val({15'h0000, ga}, p[15:0]);
            rd(`CVD_OFF_STAT, {5'h00, p[0], 2'b10});
            rd(`CVD_OFF_CTRL, 8'h03);
            till(1, 1'b1);
            rd(`CVD_OFF_STAT, {5'h00, p[0], 2'b11});
        end
        wait_done(n);
        check_val(done_n - d0, 16'h0001);
        check_val({r0h, r0l}, fmt(v_prev, 1'b0));
        check_val({r1h, r1l}, fmt(v_last, 1'b0));
        rd(`CVD_OFF_PRECTL, 8'h8b);
        rd(`CVD_OFF_STAT, 8'h00);
        rd(`CVD_OFF_CTRL, 8'h01);
        wr(`CVD_OFF_CTRL, 8'h00);
        @(negedge pclk);
        check_val({14'h0000, ga_oe_n, gb_oe_n}, 16'h0003);
        $display("test double done");
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_trig();
        t_single();
        t_double();
        complete_run();
    end
endmodule
